// ### design/fsrc_top.sv
// fsrc_top: fail-safe reaction configuration registers and output reactions
`timescale 1ns/10ps
`default_nettype none
module fsrc_top
    import fsrc_pkg::*;
#(
    parameter int PULSE_LONG = PULSE_LONG_CYC,
    parameter int PULSE_SHORT = PULSE_SHORT_CYC,
    parameter int LONG_LOW = LONG_LOW_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    input wire logic [NUM_MON-1:0] mon_under_i,
    input wire logic [NUM_MON-1:0] mon_over_i,
    input wire logic failsafe_stuck_high_i,
    input wire logic failsafe_release_i,
    input wire logic init_done_i,
    input wire logic [WD_RFR_W-1:0] wdog_refresh_count_i,
    input wire logic [WD_ERR_W-1:0] wdog_error_count_i,
    input wire logic [FLT_CNT_W-1:0] fault_error_count_i,
    output logic reset_output_n_o,
    output logic failsafe_output_n_o,
    output logic [NUM_RAIL-1:0] selftest_run_o,
    output logic clock_monitor_en_o,
    output logic lowpower_clock_monitor_en_o,
    output logic long_reset_timer_en_o,
    output logic long_reset_timeout_o
);
    localparam int PCW = $clog2(PULSE_LONG + 1);
    localparam int LCW = $clog2(LONG_LOW + 1);
    localparam int SW = 2 * NUM_MON + 1;
    // ****************************************
    // decoding helpers
    // ****************************************
    // bit 0: fail-safe asserted, bit 1: reset asserted
    function automatic logic [1:0] react(input logic [1:0] code);
        react = {code[1], code != REACT_NONE};
    endfunction
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] idx);
        hit = (a == idx);
    endfunction
    // ****************************************
    // pin synchronisers, change taken when stages 2 and 3 agree
    // ****************************************
    logic [SW-1:0] pin_raw;
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    logic [SW-1:0] sync3;
    logic [SW-1:0] pin_f;
    assign pin_raw = {failsafe_stuck_high_i, mon_over_i, mon_under_i};
    always_ff @(posedge clk_sys_i) begin
        sync1 <= pin_raw;
        sync2 <= sync1;
        sync3 <= sync2;
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pin_f <= '0;
        end else begin
            pin_f <= (sync2 & sync3) | (pin_f & (sync2 | sync3));
        end
    end

    // ****************************************
    // configuration registers
    // ****************************************
    logic [DATA_W-1:0] reaction_b;
    logic [DATA_W-1:0] selftest_ctrl;
    logic [DATA_W-1:0] wdog_cfg;
    logic [DATA_W-1:0] safe_inputs;
    logic [DATA_W-1:0] fssm_cfg;
    // only writable bits are stored; counters never enter these flops
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            reaction_b <= RST_REACTION_B;
            selftest_ctrl <= RST_SELFTEST;
            wdog_cfg <= RST_WDOG_CFG;
            safe_inputs <= RST_SAFE_INPUTS;
            fssm_cfg <= RST_FSSM_CFG;
        end else if (reg_wr_i) begin
            if (hit(reg_addr_i, IDX_REACTION_B)) begin
                reaction_b <= reg_wdata_i & WM_REACTION_B;
            end
            if (hit(reg_addr_i, IDX_SELFTEST)) begin
                selftest_ctrl <= reg_wdata_i & WM_SELFTEST;
            end
            if (hit(reg_addr_i, IDX_WDOG_CFG)) begin
                wdog_cfg <= reg_wdata_i & WM_WDOG_CFG;
            end
            if (hit(reg_addr_i, IDX_SAFE_INPUTS)) begin
                safe_inputs <= reg_wdata_i & WM_SAFE_INPUTS;
            end
            if (hit(reg_addr_i, IDX_FSSM_CFG)) begin
                fssm_cfg <= reg_wdata_i & WM_FSSM_CFG;
            end
        end
    end

    // ****************************************
    // read-back
    // ****************************************
    logic [DATA_W-1:0] wdog_view;
    logic [DATA_W-1:0] fssm_view;
    logic [DATA_W-1:0] next_rdata;
    assign wdog_view = wdog_cfg
        | (DATA_W'(wdog_refresh_count_i) << WD_RFR_LSB)
        | (DATA_W'(wdog_error_count_i) << WD_ERR_LSB);
    assign fssm_view = fssm_cfg
        | (DATA_W'(fault_error_count_i) << FLT_CNT_LSB);
    assign next_rdata =
        hit(reg_addr_i, IDX_REACTION_B) ? reaction_b :
        hit(reg_addr_i, IDX_SELFTEST) ? selftest_ctrl :
        hit(reg_addr_i, IDX_WDOG_CFG) ? wdog_view :
        hit(reg_addr_i, IDX_SAFE_INPUTS) ? safe_inputs :
        hit(reg_addr_i, IDX_FSSM_CFG) ? fssm_view : '0;
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            reg_rdata_o <= '0;
        end else if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end
    end

    // ****************************************
    // voltage monitor reactions
    // ****************************************
    logic [NUM_MON-1:0] uv_fs;
    logic [NUM_MON-1:0] uv_rst;
    logic [NUM_MON-1:0] ov_fs;
    logic [NUM_MON-1:0] ov_rst;
    logic stuck_high;
    genvar g;
    generate
        for (g = 0; g < NUM_MON; g++) begin : g_mon
            logic [1:0] ru;
            logic [1:0] ro;
            assign ru = react(reaction_b[4*g+1 -: 2]);
            assign ro = react(reaction_b[4*g+3 -: 2]);
            assign uv_fs[g] = pin_f[g] & ru[0];
            assign uv_rst[g] = pin_f[g] & ru[1];
            assign ov_fs[g] = pin_f[NUM_MON+g] & ro[0];
            assign ov_rst[g] = pin_f[NUM_MON+g] & ro[1];
        end
    endgenerate
    assign stuck_high = pin_f[SW-1];

    logic fs_req;
    logic rst_req;
    logic rst_req_q;
    logic rst_start;
    assign fs_req = |uv_fs | |ov_fs;
    assign rst_req = |uv_rst | |ov_rst
        | (stuck_high & fssm_cfg[POS_STUCK_EN]);
    assign rst_start = rst_req & ~rst_req_q;

    // fail-safe output stays asserted until released, event wins
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            failsafe_output_n_o <= 1'b1;
        end else if (fs_req) begin
            failsafe_output_n_o <= 1'b0;
        end else if (failsafe_release_i) begin
            failsafe_output_n_o <= 1'b1;
        end
    end

    // ****************************************
    // reset pulse generator
    // ****************************************
    logic [PCW-1:0] pulse_cnt;
    logic [PCW-1:0] pulse_len;
    assign pulse_len = fssm_cfg[POS_PULSE_SEL] ?
        PCW'(PULSE_SHORT) : PCW'(PULSE_LONG);

    // a new request while a pulse runs restarts the full length
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rst_req_q <= 1'b0;
            pulse_cnt <= '0;
            reset_output_n_o <= 1'b1;
        end else begin
            rst_req_q <= rst_req;
            if (rst_start) begin
                pulse_cnt <= pulse_len - PCW'(1);
                reset_output_n_o <= 1'b0;
            end else if (pulse_cnt != '0) begin
                pulse_cnt <= pulse_cnt - PCW'(1);
            end else begin
                reset_output_n_o <= 1'b1;
            end
        end
    end

    // ****************************************
    // long reset-low timer
    // ****************************************
    logic [LCW-1:0] long_cnt;
    logic long_off;
    assign long_off = fssm_cfg[POS_LONG_OFF];

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            long_cnt <= '0;
            long_reset_timeout_o <= 1'b0;
        end else if (long_off || reset_output_n_o) begin
            long_cnt <= '0;
            long_reset_timeout_o <= 1'b0;
        end else if (long_cnt != LCW'(LONG_LOW)) begin
            long_cnt <= long_cnt + LCW'(1);
        end else begin
            long_reset_timeout_o <= 1'b1;
        end
    end

    // ****************************************
    // monitor enables and self-test requests
    // ****************************************
    logic init_q;
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            init_q <= 1'b0;
            selftest_run_o <= '0;
            clock_monitor_en_o <= 1'b1;
            lowpower_clock_monitor_en_o <= 1'b1;
            long_reset_timer_en_o <= 1'b1;
        end else begin
            init_q <= init_done_i;
            selftest_run_o <= (init_done_i & ~init_q) ?
                selftest_ctrl[NUM_RAIL-1:0] : '0;
            clock_monitor_en_o <= ~fssm_cfg[POS_CLK_OFF];
            lowpower_clock_monitor_en_o <= ~fssm_cfg[POS_LPCLK_OFF];
            long_reset_timer_en_o <= ~long_off;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    AST_UV_FS: assert property (
        (|uv_fs) |=> !failsafe_output_n_o)
        else $error("undervoltage did not assert fail-safe");
    AST_OV_RST: assert property (
        $rose(|ov_rst) |=> !reset_output_n_o [*2])
        else $error("overvoltage did not assert reset");
    AST_SELFTEST: assert property (
        $rose(init_done_i) |=>
            selftest_run_o == $past(selftest_ctrl[NUM_RAIL-1:0])
            ##1 selftest_run_o == '0)
        else $error("self-test request wrong");
    AST_WD_READ: assert property (
        reg_rd_i && reg_addr_i == IDX_WDOG_CFG |=>
            reg_rdata_o[WD_RFR_LSB +: WD_RFR_W]
                == $past(wdog_refresh_count_i)
            && reg_rdata_o[WD_ERR_LSB +: WD_ERR_W]
                == $past(wdog_error_count_i))
        else $error("watchdog counters read back wrong");
    AST_PULSE_LEN: assert property (
        rst_start |=> pulse_cnt == $past(fssm_cfg[POS_PULSE_SEL] ?
            PCW'(PULSE_SHORT - 1) : PCW'(PULSE_LONG - 1)))
        else $error("reset pulse length wrong");
    AST_STUCK: assert property (
        $rose(stuck_high) && fssm_cfg[POS_STUCK_EN] |=> ##1 !reset_output_n_o)
        else $error("stuck fail-safe did not assert reset");
    AST_CLKMON: assert property (
        $changed(fssm_cfg[POS_CLK_OFF]) |=>
            clock_monitor_en_o != $past(clock_monitor_en_o))
        else $error("clock monitor enable did not follow");
    AST_LONG_OFF: assert property (
        long_off |=> long_cnt == '0 && !long_reset_timeout_o)
        else $error("long timer ran while disabled");
    AST_FLT_READ: assert property (
        reg_rd_i && reg_addr_i == IDX_FSSM_CFG |=>
            reg_rdata_o[FLT_CNT_LSB +: FLT_CNT_W] == $past(fault_error_count_i))
        else $error("fault counter read back wrong");
    AST_RO_BITS: assert property (
        reg_wr_i |=> (wdog_cfg & ~WM_WDOG_CFG) == '0
            && (fssm_cfg & ~WM_FSSM_CFG) == '0)
        else $error("host write reached a counter field");
endmodule
`default_nettype wire

// ### design/fsrc_pkg.sv
// fsrc_pkg: register indices, field layout, reset values and timing constants
package fsrc_pkg;
    // ****************************************
    // register indices on the register port
    // ****************************************
    localparam int ADDR_W = 3;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] IDX_REACTION_B = 3'h0;
    localparam logic [ADDR_W-1:0] IDX_SELFTEST = 3'h1;
    localparam logic [ADDR_W-1:0] IDX_WDOG_CFG = 3'h2;
    localparam logic [ADDR_W-1:0] IDX_SAFE_INPUTS = 3'h3;
    localparam logic [ADDR_W-1:0] IDX_FSSM_CFG = 3'h4;
    // ****************************************
    // reset values and writable masks
    // ****************************************
    localparam logic [DATA_W-1:0] RST_REACTION_B = 16'h9999;
    localparam logic [DATA_W-1:0] RST_SELFTEST = 16'h0000;
    localparam logic [DATA_W-1:0] RST_WDOG_CFG = 16'h4200;
    localparam logic [DATA_W-1:0] RST_SAFE_INPUTS = 16'h41ca;
    localparam logic [DATA_W-1:0] RST_FSSM_CFG = 16'h5080;
    localparam logic [DATA_W-1:0] WM_REACTION_B = 16'hffff;
    localparam logic [DATA_W-1:0] WM_SELFTEST = 16'h007f;
    localparam logic [DATA_W-1:0] WM_WDOG_CFG = 16'hdb00;
    localparam logic [DATA_W-1:0] WM_SAFE_INPUTS = 16'hddcf;
    localparam logic [DATA_W-1:0] WM_FSSM_CFG = 16'hdaf0;
    // ****************************************
    // field positions
    // ****************************************
    localparam int NUM_MON = 4;
    localparam int NUM_RAIL = 7;
    localparam int WD_RFR_LSB = 4;
    localparam int WD_RFR_W = 3;
    localparam int WD_ERR_LSB = 0;
    localparam int WD_ERR_W = 4;
    localparam int FLT_CNT_LSB = 0;
    localparam int FLT_CNT_W = 4;
    localparam int POS_PULSE_SEL = 9;
    localparam int POS_STUCK_EN = 7;
    localparam int POS_LPCLK_OFF = 6;
    localparam int POS_CLK_OFF = 5;
    localparam int POS_LONG_OFF = 4;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ = 20_000_000;
    localparam int PULSE_LONG_MS = 10;
    localparam int PULSE_SHORT_MS = 1;
    localparam int LONG_LOW_S = 8;
    localparam int PULSE_LONG_CYC = CLK_HZ / 1000 * PULSE_LONG_MS;
    localparam int PULSE_SHORT_CYC = CLK_HZ / 1000 * PULSE_SHORT_MS;
    localparam int LONG_LOW_CYC = CLK_HZ * LONG_LOW_S;
    localparam logic [1:0] REACT_NONE = 2'h0;
endpackage

// ### tb/fsrc_host.sv
// fsrc_host: host model driving the register port of the block
`timescale 1ns/10ps
`default_nettype none
module fsrc_host
    import fsrc_pkg::*;
(
    input wire logic clk_i,
    output logic wr_o,
    output logic rd_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic [DATA_W-1:0] wdata_o
);
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 3'h7;
        wdata_o = 16'h0;
    end
    // one strobe per call; idle bus shows inverted values, never stale ones
    task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d);
        @(negedge clk_i);
        wr_o = wr;
        rd_o = !wr;
        addr_o = a;
        wdata_o = d;
        @(negedge clk_i);
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
// tb: self-checking bench for the fail-safe reaction registers
`timescale 1ns/10ps
`default_nettype none
module tb;
    import fsrc_pkg::*;
    localparam int P_LONG = 20;
    localparam int P_SHORT = 4;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic reg_wr, reg_rd;
    logic rd_d = 1'b0;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, r;
    logic [NUM_MON-1:0] mon_under = '0;
    logic [NUM_MON-1:0] mon_over = '0;
    logic stuck_hi = 1'b0;
    logic fs_release = 1'b0;
    logic init_done = 1'b0;
    logic [2:0] rfr_cnt = '0;
    logic [3:0] err_cnt = '0;
    logic [3:0] flt_cnt = '0;
    logic rst_n_o, fs_n_o, clk_en, lpclk_en, long_en, long_to;
    logic [NUM_RAIL-1:0] st_run;
    logic [DATA_W-1:0] exp_q[$];
    logic [DATA_W-1:0] wm[5] = '{WM_REACTION_B, WM_SELFTEST, WM_WDOG_CFG,
                                 WM_SAFE_INPUTS, WM_FSSM_CFG};
    logic [DATA_W-1:0] rstv[5] = '{RST_REACTION_B, RST_SELFTEST,
                                   RST_WDOG_CFG, RST_SAFE_INPUTS, RST_FSSM_CFG};
    int bad_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    int lows;
    integer seed = 32'h80f75910;
    always #25 clk_sys_i = ~clk_sys_i;
    fsrc_host host (.clk_i(clk_sys_i), .wr_o(reg_wr), .rd_o(reg_rd),
                    .addr_o(reg_addr), .wdata_o(reg_wdata));
    fsrc_top #(.PULSE_LONG(P_LONG), .PULSE_SHORT(P_SHORT), .LONG_LOW(50)) DUT (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_rdata_o(reg_rdata), .mon_under_i(mon_under),
        .mon_over_i(mon_over), .failsafe_stuck_high_i(stuck_hi),
        .failsafe_release_i(fs_release), .init_done_i(init_done),
        .wdog_refresh_count_i(rfr_cnt), .wdog_error_count_i(err_cnt),
        .fault_error_count_i(flt_cnt), .reset_output_n_o(rst_n_o),
        .failsafe_output_n_o(fs_n_o), .selftest_run_o(st_run),
        .clock_monitor_en_o(clk_en), .lowpower_clock_monitor_en_o(lpclk_en),
        .long_reset_timer_en_o(long_en), .long_reset_timeout_o(long_to));
    // ****************************************
    // checking helpers
    // ****************************************
    task automatic end_sim();
        if (bad_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic fail(input string m);
        bad_count++;
        $display("mismatch at %0t: %s", $time, m);
    endtask
    task automatic cmp_reg(input logic [15:0] got, input logic [15:0] e);
        cmp_count++;
        if (got !== e)
            fail($sformatf("read %h expected %h", got, e));
    endtask
    task automatic cmp_bit(input logic got, input logic e, input string m);
        cmp_count++;
        if (got !== e)
            fail(m);
    endtask
    // read data stands from the edge after the strobe, so look at the fall
    always @(posedge clk_sys_i) rd_d <= reg_rd;
    always @(negedge clk_sys_i) begin
        if (rd_d)
            cmp_reg(reg_rdata, exp_q.pop_front());
    end
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_sim();
        end
    end
    task automatic rd(input logic [2:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        host.access(1'b0, a, 16'h0);
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        host.access(1'b1, a, d);
    endtask
    function automatic logic [15:0] cnt(input int i);
        if (i == 2)
            return {9'h0, rfr_cnt, err_cnt};
        return (i == 4) ? {12'h0, flt_cnt} : 16'h0;
    endfunction
    task automatic new_counts();
        @(negedge clk_sys_i);
        rfr_cnt = 3'($random(seed));
        err_cnt = 4'($random(seed));
        flt_cnt = 4'({$random(seed)} % 13);
    endtask
    task automatic settle();
        fs_release = 1'b1;
        repeat (P_LONG + 10) @(negedge clk_sys_i);
        fs_release = 1'b0;
    endtask
    task automatic react(input int n, input int ov, input logic [1:0] c);
        wr(IDX_REACTION_B, 16'(c) << (4 * n + 2 * ov));
        @(negedge clk_sys_i);
        if (ov == 1)
            mon_over[n] = 1'b1;
        else
            mon_under[n] = 1'b1;
        repeat (8) @(negedge clk_sys_i);
        cmp_bit(fs_n_o, c == 2'h0, "fail-safe reaction");
        cmp_bit(rst_n_o, !c[1], "reset reaction");
        mon_over = '0;
        mon_under = '0;
        settle();
        cmp_bit(fs_n_o & rst_n_o, 1'b1, "outputs not released");
    endtask
    // a held fault must give one pulse only, so count every low cycle
    task automatic pulse(input logic [15:0] cfg, input int len);
        wr(IDX_FSSM_CFG, cfg);
        @(negedge clk_sys_i);
        stuck_hi = 1'b1;
        lows = 0;
        repeat (P_LONG + 12) begin
            @(negedge clk_sys_i);
            lows += int'(rst_n_o === 1'b0);
        end
        cmp_bit(lows == len, 1'b1, "reset pulse length");
        stuck_hi = 1'b0;
        settle();
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (3) @(negedge clk_sys_i);
        rst_i = 1'b0;
        new_counts();
        for (int i = 0; i < 5; i++)
            rd(3'(i), rstv[i] | cnt(i));
        rd(3'h7, 16'h0);
        cmp_bit(clk_en & lpclk_en & long_en, 1'b1, "enables at reset");
        for (int i = 0; i < 6; i++) begin
            new_counts();
            r = 16'($random(seed));
            wr(3'(i), r);
            rd(3'(i), (i < 5) ? ((r & wm[i]) | cnt(i)) : 16'h0);
        end
        for (int n = 0; n < NUM_MON; n++)
            for (int ov = 0; ov < 2; ov++)
                for (int c = 0; c < 4; c++)
                    react(n, ov, 2'(c));
        pulse(16'h0280, P_SHORT);
        pulse(16'h0080, P_LONG);
        pulse(16'h0000, 0);
        // restarts every 10 cycles keep reset low past the long-low limit
        wr(IDX_FSSM_CFG, 16'h0080);
        repeat (8) begin
            stuck_hi = 1'b1;
            repeat (5) @(negedge clk_sys_i);
            stuck_hi = 1'b0;
            repeat (5) @(negedge clk_sys_i);
        end
        cmp_bit(long_to, 1'b1, "long reset-low timeout");
        wr(IDX_FSSM_CFG, 16'h0090);
        repeat (2) @(negedge clk_sys_i);
        cmp_bit(long_to, 1'b0, "long timer not disabled");
        settle();
        repeat (4) begin
            r = 16'($random(seed));
            wr(IDX_FSSM_CFG, r);
            repeat (2) @(negedge clk_sys_i);
            cmp_bit(clk_en, !r[POS_CLK_OFF], "clock monitor");
            cmp_bit(lpclk_en, !r[POS_LPCLK_OFF], "low-power monitor");
            cmp_bit(long_en, !r[POS_LONG_OFF], "long reset timer");
        end
        // a mid-run reset must bring every writable field back to its default
        rst_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        rst_i = 1'b0;
        for (int i = 0; i < 5; i++)
            rd(3'(i), rstv[i] | cnt(i));
        cmp_bit(clk_en & lpclk_en & long_en, 1'b1, "enables after reset");
        r = 16'($random(seed)) | 16'h0001;
        wr(IDX_SELFTEST, r);
        @(negedge clk_sys_i);
        init_done = 1'b1;
        for (int k = 0; k < 4 && st_run === '0; k++)
            @(negedge clk_sys_i);
        cmp_reg({9'h0, st_run}, r & 16'h007f);
        end_sim();
    end
endmodule
`default_nettype wire
